/* hdl/ucd_pkg.sv */
// shared constants and types of the charger detect control block
package ucd_pkg;

	localparam logic [6:0] UCD_I2C_ADDR = 7'h2C;

	localparam logic [7:0] REG_STATUS   = 8'h00;
	localparam logic [7:0] REG_CTRL1    = 8'h01;
	localparam logic [7:0] REG_INT      = 8'h02;
	localparam logic [7:0] REG_CTRL2    = 8'h03;

	localparam logic [7:0] CTRL1_RESET  = 8'h00;
	localparam logic [7:0] CTRL2_RESET  = 8'h00;
	localparam logic [2:0] FLAGS_RESET  = 3'h0;

	localparam int C1_IRQ_EN    = 0;
	localparam int C1_LOW_POWER_SELECT   = 1;
	localparam int C1_CP_EN     = 2;
	localparam int C1_FORCE_DET = 3;
	localparam int C1_CE_OVR    = 4;
	localparam int C2_DSC_LSB   = 0;
	localparam int C2_CE_LSB    = 2;

	localparam int INT_VBUS     = 0;
	localparam int INT_CHG      = 1;
	localparam int INT_DCD      = 2;

	localparam int SY_VBUS      = 0;
	localparam int SY_DCD       = 1;
	localparam int SY_TYPE      = 2;
	localparam int SY_SCL       = 4;
	localparam int SY_SDA       = 5;
	localparam int SY_CE        = 6;
	localparam int SYNC_W       = 9;

	localparam logic [3:0] BYTE_BITS = 4'h8;

	localparam int CLK_MHZ      = 100;
	localparam int DEBOUNCE_US  = 30000;
	localparam int DETECT_US    = 1000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
	localparam int DETECT_CYC   = DETECT_US * CLK_MHZ;

	typedef enum logic [1:0] {
		CHG_NONE = 2'b00,
		CHG_SDP  = 2'b01,
		CHG_CDP  = 2'b10,
		CHG_DCP  = 2'b11
	} ucd_chg_t;

	typedef enum logic {
		DET_IDLE = 1'b0,
		DET_RUN  = 1'b1
	} ucd_det_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ADDR    = 3'b001,
		ST_ADDR_AK = 3'b010,
		ST_WR      = 3'b011,
		ST_WR_AK   = 3'b100,
		ST_RD      = 3'b101,
		ST_RD_AK   = 3'b110
	} ucd_i2c_st_t;

endpackage : ucd_pkg

/* hdl/ucd_i2c_slave.sv */
// serial register port slave with auto-incrementing pointer
`timescale 1ns/1ps
module ucd_i2c_slave
	import ucd_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// filtered bus levels
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_oe_n,
	// register side
	input  wire logic [7:0] rd_data,
	output logic            rd_req,
	output logic [7:0]      ptr,
	output logic            wr_stb,
	output logic [7:0]      wr_addr,
	output logic [7:0]      wr_data
);

	ucd_i2c_st_t st_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q;
	logic        rw_q;
	logic        first_q;
	logic        scl_p_q;
	logic        sda_p_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;

	assign scl_rise = scl & ~scl_p_q;
	assign scl_fall = ~scl & scl_p_q;
	assign start_c  = scl & scl_p_q & sda_p_q & ~sda;
	assign stop_c   = scl & scl_p_q & ~sda_p_q & sda;
	// data word is taken in the same cycle as the load, so a later event waits
	assign rd_req   = scl_fall & ((st_q == ST_ADDR_AK & rw_q) | (st_q == ST_RD_AK & ~sh_q[0]));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl;
			sda_p_q <= sda;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q     <= ST_IDLE;
			cnt_q    <= 4'h0;
			sh_q     <= 8'h00;
			rw_q     <= 1'b0;
			first_q  <= 1'b0;
			sda_oe_n <= 1'b1;
			ptr      <= 8'h00;
			wr_stb   <= 1'b0;
			wr_addr  <= 8'h00;
			wr_data  <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (start_c) begin
				st_q     <= ST_ADDR;
				cnt_q    <= 4'h0;
				sda_oe_n <= 1'b1;
			end else if (stop_c) begin
				st_q     <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else begin
				case (st_q)
					ST_ADDR, ST_WR: begin
						if (scl_rise) begin
							sh_q  <= {sh_q[6:0], sda};
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == BYTE_BITS) begin
							if (st_q == ST_WR) begin
								sda_oe_n <= 1'b0;
								st_q     <= ST_WR_AK;
								if (first_q) begin
									ptr <= sh_q;
								end else begin
									wr_stb  <= 1'b1;
									wr_addr <= ptr;
									wr_data <= sh_q;
									ptr     <= ptr + 8'h01;
								end
							end else if (sh_q[7:1] == UCD_I2C_ADDR) begin
								sda_oe_n <= 1'b0;
								rw_q     <= sh_q[0];
								st_q     <= ST_ADDR_AK;
							end else begin
								st_q <= ST_IDLE;
							end
						end
					end
					ST_WR_AK: begin
						if (scl_fall) begin
							sda_oe_n <= 1'b1;
							first_q  <= 1'b0;
							cnt_q    <= 4'h0;
							st_q     <= ST_WR;
						end
					end
					ST_ADDR_AK, ST_RD_AK: begin
						if (scl_rise && st_q == ST_RD_AK) begin
							sh_q[0] <= sda;
						end else if (rd_req) begin
							sh_q     <= rd_data;
							sda_oe_n <= rd_data[7];
							ptr      <= ptr + 8'h01;
							cnt_q    <= 4'h0;
							st_q     <= ST_RD;
						end else if (scl_fall) begin
							sda_oe_n <= 1'b1;
							first_q  <= 1'b1;
							cnt_q    <= 4'h0;
							st_q     <= (st_q == ST_ADDR_AK) ? ST_WR : ST_IDLE;
						end
					end
					ST_RD: begin
						if (scl_fall) begin
							cnt_q <= cnt_q + 4'h1;
							if (cnt_q == BYTE_BITS - 4'h1) begin
								sda_oe_n <= 1'b1;
								st_q     <= ST_RD_AK;
							end else begin
								sda_oe_n <= sh_q[6];
								sh_q     <= {sh_q[6:0], 1'b0};
							end
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	property p_ptr_only;
		@(posedge clk) disable iff (!rst_n)
		(st_q == ST_WR && first_q && scl_fall && cnt_q == BYTE_BITS && !start_c && !stop_c)
			|=> (!wr_stb && ptr == $past(sh_q));
	endproperty
	a_ptr_only: assert property (p_ptr_only) else $error("pointer byte wrote a register");

	property p_ptr_inc;
		@(posedge clk) disable iff (!rst_n)
		wr_stb |-> (ptr == wr_addr + 8'h01);
	endproperty
	a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");

	property p_nack_release;
		@(posedge clk) disable iff (!rst_n)
		(st_q == ST_RD_AK && scl_fall && sh_q[0] && !start_c && !stop_c)
			|=> (sda_oe_n && st_q == ST_IDLE);
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("data driven after nack");

endmodule : ucd_i2c_slave

/* hdl/ucd_ctrl.sv */
// charger detect control: pin sync, debounce, detection, flags, outputs
//
// Overview of operation
// - flag bus change, detect done, contact timeout
// - enable bit gates the interrupt pin
// - masked flags stay latched, pin quiet
// - flags clear only on interrupt register read
// - bus state must hold for debounce time
// - low power stops oscillator when fully idle
// - low power opens every switch
// - pump enable bit drives pump output
// - pump enable resets to zero
// - detection starts on bus arrival or force
// - switches open during detection, then restored
// - open drain charger enables from detected type
// - override makes enables follow written bits
// - serial port is a slave only
// - clock input only, data open drain
// - answers to its seven bit address
// - first written byte loads the pointer
// - each data byte uses then bumps pointer
// - master nack stops the read data
`timescale 1ns/1ps
module ucd_ctrl
	import ucd_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
	parameter int DETECT_CYCLES   = DETECT_CYC
) (
	// clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RESETN,
	// serial register port
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE_N,
	// analog detector status
	input  wire logic       VBUS_COMP,
	input  wire logic       CONTACT_TIMEOUT,
	input  wire logic [1:0] CHARGER_TYPE,
	// charger enable pins
	input  wire logic [2:0] CHARGER_ENABLE_IN,
	output logic      [2:0] CHARGER_ENABLE_OUT,
	output logic      [2:0] CHARGER_ENABLE_OE_N,
	// interrupt, power and switches
	output logic            IRQ_N,
	output logic            OSC_ENABLE,
	output logic            CHARGE_PUMP_ON,
	output logic            SWITCH_DATA_PLUS_EN,
	output logic            SWITCH_DATA_MINUS_EN,
	output logic            DETECT_ACTIVE
);

	localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);
	localparam int DET_W = $clog2(DETECT_CYCLES + 1);
	// bus pins idle high; starting there avoids a false edge after reset
	localparam logic [SYNC_W-1:0] SYNC_IDLE = (SYNC_W'(1) << SY_SCL) | (SYNC_W'(1) << SY_SDA);

	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] s3_q;
	logic [SYNC_W-1:0] filt_q;
	logic [SYNC_W-1:0] pins;
	logic [DEB_W-1:0]  deb_cnt_q;
	logic              vbus_q;
	logic              deb_done;
	logic [DET_W-1:0]  det_cnt_q;
	ucd_det_t          det_q;
	ucd_chg_t          chg_q;
	logic              det_done;
	logic              dcd_p_q;
	logic [7:0]        ctrl1_q;
	logic [7:0]        ctrl2_q;
	logic [2:0]        flags_q;
	logic [2:0]        ev;
	logic              force_req;
	logic              clr_int;
	logic              rd_req;
	logic [7:0]        ptr;
	logic [7:0]        rd_data;
	logic              wr_stb;
	logic [7:0]        wr_addr;
	logic [7:0]        wr_data;
	logic              sw_open;

	function automatic logic [2:0] ce_auto(input ucd_chg_t t);
		case (t)
			CHG_SDP: ce_auto = 3'h1;
			CHG_CDP: ce_auto = 3'h3;
			CHG_DCP: ce_auto = 3'h7;
			default: ce_auto = 3'h0;
		endcase
	endfunction : ce_auto

	assign pins = {CHARGER_ENABLE_IN, SDA_IN, SCL, CHARGER_TYPE, CONTACT_TIMEOUT, VBUS_COMP};

	// a level only moves once the last two stages agree
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			s1_q   <= SYNC_IDLE;
			s2_q   <= SYNC_IDLE;
			s3_q   <= SYNC_IDLE;
			filt_q <= SYNC_IDLE;
		end else begin
			s1_q   <= pins;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= (filt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
		end
	end

	ucd_i2c_slave u_slave (
		.clk      (REF_CLK),
		.rst_n    (RESETN),
		.scl      (filt_q[SY_SCL]),
		.sda      (filt_q[SY_SDA]),
		.sda_oe_n (SDA_OE_N),
		.rd_data  (rd_data),
		.rd_req   (rd_req),
		.ptr      (ptr),
		.wr_stb   (wr_stb),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data)
	);

	// open drain: only the enable moves, the driven level is always low
	assign SDA_OUT            = 1'b0;
	assign CHARGER_ENABLE_OUT = 3'h0;

	assign deb_done = (filt_q[SY_VBUS] != vbus_q) &&
		(deb_cnt_q == DEB_W'(DEBOUNCE_CYCLES - 1));

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			deb_cnt_q <= '0;
			vbus_q    <= 1'b0;
		end else if (filt_q[SY_VBUS] == vbus_q || deb_done) begin
			deb_cnt_q <= '0;
			vbus_q    <= filt_q[SY_VBUS];
		end else begin
			deb_cnt_q <= deb_cnt_q + DEB_W'(1);
		end
	end

	assign force_req = wr_stb && wr_addr == REG_CTRL1 && wr_data[C1_FORCE_DET];
	assign det_done  = det_q == DET_RUN && det_cnt_q == DET_W'(DETECT_CYCLES - 1);

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			det_q     <= DET_IDLE;
			det_cnt_q <= '0;
			chg_q     <= CHG_NONE;
		end else if (deb_done && !filt_q[SY_VBUS]) begin
			det_q <= DET_IDLE;
			chg_q <= CHG_NONE;
		end else if (force_req || (deb_done && filt_q[SY_VBUS])) begin
			det_q     <= DET_RUN;
			det_cnt_q <= '0;
		end else begin
			case (det_q)
				DET_RUN: begin
					det_cnt_q <= det_cnt_q + DET_W'(1);
					if (det_done) begin
						det_q <= DET_IDLE;
						chg_q <= ucd_chg_t'(filt_q[SY_TYPE +: 2]);
					end
				end
				default: det_q <= DET_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl1_q <= CTRL1_RESET;
			ctrl2_q <= CTRL2_RESET;
		end else if (wr_stb) begin
			case (wr_addr)
				// force request is a pulse, the stored bit reads back zero
				REG_CTRL1: ctrl1_q <= wr_data & ~(8'h01 << C1_FORCE_DET);
				REG_CTRL2: ctrl2_q <= wr_data;
				default:   ;
			endcase
		end
	end

	assign ev[INT_VBUS] = deb_done;
	assign ev[INT_CHG]  = det_done;
	assign ev[INT_DCD]  = filt_q[SY_DCD] & ~dcd_p_q;
	assign clr_int      = rd_req && ptr == REG_INT;

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			flags_q <= FLAGS_RESET;
			dcd_p_q <= 1'b0;
		end else begin
			dcd_p_q <= filt_q[SY_DCD];
			flags_q <= (clr_int ? FLAGS_RESET : flags_q) | ev;
		end
	end

	always_comb begin
		case (ptr)
			REG_STATUS: rd_data = {filt_q[SY_CE +: 3], det_q == DET_RUN, filt_q[SY_DCD],
				chg_q, vbus_q};
			REG_CTRL1:  rd_data = ctrl1_q;
			REG_INT:    rd_data = {5'h00, flags_q};
			REG_CTRL2:  rd_data = ctrl2_q;
			default:    rd_data = 8'h00;
		endcase
	end

	assign sw_open = ctrl1_q[C1_LOW_POWER_SELECT] | (det_q == DET_RUN);

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			IRQ_N                <= 1'b1;
			OSC_ENABLE           <= 1'b1;
			CHARGE_PUMP_ON       <= 1'b0;
			SWITCH_DATA_PLUS_EN  <= 1'b0;
			SWITCH_DATA_MINUS_EN <= 1'b0;
			CHARGER_ENABLE_OE_N  <= 3'h0;
			DETECT_ACTIVE        <= 1'b0;
		end else begin
			IRQ_N                <= ~(ctrl1_q[C1_IRQ_EN] & |flags_q);
			OSC_ENABLE           <= ~(ctrl1_q[C1_LOW_POWER_SELECT] & ~vbus_q & ~ctrl1_q[C1_CP_EN] &
				(ctrl2_q[C2_DSC_LSB +: 2] == 2'h0));
			CHARGE_PUMP_ON       <= ctrl1_q[C1_CP_EN];
			SWITCH_DATA_PLUS_EN  <= ~sw_open & ctrl2_q[C2_DSC_LSB];
			SWITCH_DATA_MINUS_EN <= ~sw_open & ctrl2_q[C2_DSC_LSB + 1];
			CHARGER_ENABLE_OE_N  <= ctrl1_q[C1_CE_OVR] ? ctrl2_q[C2_CE_LSB +: 3] : ce_auto(chg_q);
			DETECT_ACTIVE        <= det_q == DET_RUN;
		end
	end

	property p_bus_event;
		@(posedge REF_CLK) disable iff (!RESETN)
		$changed(vbus_q) |-> flags_q[INT_VBUS];
	endproperty
	a_bus_event: assert property (p_bus_event) else $error("bus change not flagged");

	property p_irq_gate;
		@(posedge REF_CLK) disable iff (!RESETN)
		!ctrl1_q[C1_IRQ_EN] |=> IRQ_N;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt pin not masked");

	property p_masked_kept;
		@(posedge REF_CLK) disable iff (!RESETN)
		(!ctrl1_q[C1_IRQ_EN] && !clr_int) |=> ((flags_q & $past(flags_q)) == $past(flags_q));
	endproperty
	a_masked_kept: assert property (p_masked_kept) else $error("masked flag was lost");

	property p_clear_by_read;
		@(posedge REF_CLK) disable iff (!RESETN)
		((~flags_q & $past(flags_q)) != 3'h0) |-> $past(clr_int);
	endproperty
	a_clear_by_read: assert property (p_clear_by_read) else $error("flag cleared without read");

	property p_debounce;
		@(posedge REF_CLK) disable iff (!RESETN)
		$changed(vbus_q) |-> $past(deb_cnt_q) == DEB_W'(DEBOUNCE_CYCLES - 1);
	endproperty
	a_debounce: assert property (p_debounce) else $error("bus state moved early");

	property p_osc_stop;
		@(posedge REF_CLK) disable iff (!RESETN)
		(ctrl1_q[C1_LOW_POWER_SELECT] && !vbus_q && !ctrl1_q[C1_CP_EN] && ctrl2_q[C2_DSC_LSB +: 2] == 2'h0)
			|=> !OSC_ENABLE;
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("oscillator left running");

	property p_switch_open;
		@(posedge REF_CLK) disable iff (!RESETN)
		(ctrl1_q[C1_LOW_POWER_SELECT] || det_q == DET_RUN)
			|=> (!SWITCH_DATA_PLUS_EN && !SWITCH_DATA_MINUS_EN);
	endproperty
	a_switch_open: assert property (p_switch_open) else $error("switch closed while isolated");

	property p_force_start;
		@(posedge REF_CLK) disable iff (!RESETN)
		force_req |=> (det_q == DET_RUN) ##1 DETECT_ACTIVE;
	endproperty
	a_force_start: assert property (p_force_start) else $error("forced detection not started");

	property p_override;
		@(posedge REF_CLK) disable iff (!RESETN)
		ctrl1_q[C1_CE_OVR] |=> CHARGER_ENABLE_OE_N == $past(ctrl2_q[C2_CE_LSB +: 3]);
	endproperty
	a_override: assert property (p_override) else $error("override value not driven");

	property p_irq_on;
		@(posedge REF_CLK) disable iff (!RESETN)
		(ctrl1_q[C1_IRQ_EN] && flags_q != 3'h0) |=> !IRQ_N;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("pending interrupt not shown");

endmodule : ucd_ctrl

/* tb/ucd_i2c_host.sv */
// serial bus master model that talks to the register port of the block
`timescale 1ns/1ps
module ucd_i2c_host (
	// bench clock, only used to keep pin edges off its sampling edge
	input  wire logic clk,
	// device side of the open drain data line
	input  wire logic dev_oe_n,
	// bus wires as every party sees them
	output logic      scl,
	output logic      sda_line
);
	logic m_sda;

	assign sda_line = m_sda & dev_oe_n;

	initial begin
		scl   = 1'b1;
		m_sda = 1'b1;
	end

	task automatic start_cond();
		// frames begin just after an edge; every later step is a multiple of 2.5 ns
		@(posedge clk);
		#31.25 m_sda = 1'b1;
		#32.5 scl = 1'b1;
		#62.5 m_sda = 1'b0;
		#62.5 scl = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		#30 m_sda = 1'b0;
		#32.5 scl = 1'b1;
		#62.5 m_sda = 1'b1;
		#62.5;
	endtask : stop_cond

	// data moves well after the clock falls so no false start or stop is seen
	task automatic bit_io(input logic tx, output logic rx);
		#30 m_sda = tx;
		#32.5 scl = 1'b1;
		#62.5 rx = sda_line;
		scl = 1'b0;
	endtask : bit_io

	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, ack_out);
	endtask : xfer
endmodule : ucd_i2c_host

/* tb/tb_usb_charger_detect_control.sv */
// self-checking bench of the charger detect control block
`timescale 1ns/1ps
module tb_usb_charger_detect_control
	import ucd_pkg::*;
;
	// short counts keep the run brief
	localparam int DEB = 50;
	localparam int DET = 40;

	logic       ref_clk, resetn, scl, sda_line, sda_oe_n, vbus, ctmo;
	logic       irq_n, osc_en, pump_on, sw_plus, sw_minus, det_act, ack;
	logic [1:0] ctype, typ;
	logic [2:0] ce_in, ce_oe_n, ce_out;
	logic       sda_out;
	logic [7:0] c2;
	logic [7:0] got [3];
	logic [7:0] expv [3];
	int         fail_count, check_count, cycles, ptr_m, ctrl1_m, ctrl2_m, flags_m;

	// charger enable pins have pull-ups, so readback is the released level
	assign ce_in = ce_oe_n;

	ucd_i2c_host host_u (
		.clk      (ref_clk),
		.dev_oe_n (sda_oe_n),
		.scl      (scl),
		.sda_line (sda_line)
	);

	ucd_ctrl #(
		.DEBOUNCE_CYCLES (DEB),
		.DETECT_CYCLES   (DET)
	) dut_u (
		.REF_CLK              (ref_clk),
		.RESETN               (resetn),
		.SCL                  (scl),
		.SDA_IN               (sda_line),
		.SDA_OUT              (sda_out),
		.SDA_OE_N             (sda_oe_n),
		.VBUS_COMP            (vbus),
		.CONTACT_TIMEOUT      (ctmo),
		.CHARGER_TYPE         (ctype),
		.CHARGER_ENABLE_IN    (ce_in),
		.CHARGER_ENABLE_OUT   (ce_out),
		.CHARGER_ENABLE_OE_N  (ce_oe_n),
		.IRQ_N                (irq_n),
		.OSC_ENABLE           (osc_en),
		.CHARGE_PUMP_ON       (pump_on),
		.SWITCH_DATA_PLUS_EN  (sw_plus),
		.SWITCH_DATA_MINUS_EN (sw_minus),
		.DETECT_ACTIVE        (det_act)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	// a hang counts as a mismatch
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t value mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	task automatic tdone(input string s);
		$display("test %0s finished", s);
	endtask : tdone

	// model view of a register; the force bit never reads back
	function automatic logic [7:0] exp_reg(input int a);
		case (a)
			1: return 8'(ctrl1_m) & 8'hF7;
			2: return 8'(flags_m);
			3: return 8'(ctrl2_m);
			default: return 8'h00;
		endcase
	endfunction : exp_reg

	task automatic put(input logic [7:0] b);
		logic [7:0] r;
		logic       a;
		host_u.xfer(b, 1'b1, r, a);
		check({7'h00, a}, 8'h00);
	endtask : put

	task automatic wr(input logic [7:0] p, input int n, input logic [7:0] d0, d1, d2);
		logic [7:0] d [3];
		d = '{d0, d1, d2};
		host_u.start_cond();
		put({UCD_I2C_ADDR, 1'b0});
		put(p);
		ptr_m = p;
		for (int i = 0; i < n; i++) begin
			put(d[i]);
			if (ptr_m == 1) ctrl1_m = d[i];
			if (ptr_m == 3) ctrl2_m = d[i];
			ptr_m = (ptr_m + 1) % 256;
		end
		host_u.stop_cond();
	endtask : wr

	task automatic rd(input logic [7:0] p, input int n, input bit setp);
		logic a;
		if (setp) begin
			host_u.start_cond();
			put({UCD_I2C_ADDR, 1'b0});
			put(p);
			ptr_m = p;
		end
		host_u.start_cond();
		put({UCD_I2C_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			expv[i] = exp_reg(ptr_m);
			if (ptr_m == 2) flags_m = 0;
			ptr_m = (ptr_m + 1) % 256;
			host_u.xfer(8'hFF, (i == n - 1), got[i], a);
		end
		host_u.stop_cond();
	endtask : rd

	initial begin
		void'($urandom(44));
		resetn  = 1'b0;
		vbus    = 1'b0;
		ctmo    = 1'b0;
		ctype   = 2'h0;
		ctrl1_m = CTRL1_RESET;
		ctrl2_m = CTRL2_RESET;
		flags_m = FLAGS_RESET;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		cyc(20);

		rd(REG_CTRL1, 2, 1);
		for (int i = 0; i < 2; i++) check(got[i], expv[i]);
		check({7'h00, pump_on}, 8'h00);
		check({7'h00, irq_n}, 8'h01);
		check({4'h0, sda_out, ce_out}, 8'h00);
		tdone("reset");

		c2 = {3'b000, 3'($urandom), 2'b11};
		wr(REG_CTRL1, 3, 8'h01, 8'hFF, c2);
		rd(REG_CTRL1, 3, 1);
		for (int i = 0; i < 3; i++) check(got[i], expv[i]);
		check({6'h00, sw_minus, sw_plus}, 8'h03);
		wr(REG_CTRL2, 0, 8'h00, 8'h00, 8'h00);
		rd(8'h00, 1, 0);
		check(got[0], c2);
		host_u.start_cond();
		host_u.xfer(8'h5A, 1'b1, got[0], ack);
		host_u.stop_cond();
		check({7'h00, ack}, 8'h01);
		tdone("port");

		// a glitch shorter than the debounce must stay silent
		@(posedge ref_clk) vbus <= 1'b1;
		cyc(DEB / 2);
		vbus <= 1'b0;
		cyc(DEB + 30);
		check({7'h00, irq_n}, 8'h01);
		typ = 2'($urandom);
		ctype <= typ;
		vbus  <= 1'b1;
		cyc(DEB + 20);
		check({7'h00, det_act}, 8'h01);
		check({6'h00, sw_minus, sw_plus}, 8'h00);
		cyc(DET + 40);
		check({6'h00, sw_minus, sw_plus}, 8'h03);
		check({5'h00, ce_oe_n}, 8'((1 << typ) - 1));
		check({7'h00, irq_n}, 8'h00);
		flags_m = 3;
		rd(REG_INT, 1, 1);
		check(got[0], expv[0]);
		check({7'h00, irq_n}, 8'h01);
		rd(REG_INT, 1, 1);
		check(got[0], expv[0]);
		tdone("attach");

		wr(REG_CTRL1, 1, 8'h00, 8'h00, 8'h00);
		@(posedge ref_clk) ctmo <= 1'b1;
		cyc(20);
		check({7'h00, irq_n}, 8'h01);
		ctmo <= 1'b0;
		wr(REG_CTRL1, 1, 8'h01, 8'h00, 8'h00);
		cyc(5);
		check({7'h00, irq_n}, 8'h00);
		flags_m = 4;
		rd(REG_INT, 1, 1);
		check(got[0], expv[0]);
		tdone("mask");

		c2 = {3'b000, 3'($urandom), 2'b11};
		wr(REG_CTRL1, 3, 8'h11, 8'h00, c2);
		cyc(5);
		check({5'h00, ce_oe_n}, {5'h00, c2[4:2]});
		@(posedge ref_clk) vbus <= 1'b0;
		cyc(DEB + 20);
		check({7'h00, irq_n}, 8'h00);
		flags_m = 1;
		rd(REG_INT, 1, 1);
		check(got[0], expv[0]);
		tdone("override and detach");

		wr(REG_CTRL1, 3, 8'h02, 8'h00, 8'h00);
		cyc(5);
		check({7'h00, osc_en}, 8'h00);
		wr(REG_CTRL1, 3, 8'h06, 8'h00, 8'h03);
		cyc(5);
		check({4'h0, osc_en, pump_on, sw_minus, sw_plus}, 8'h0C);
		tdone("low power");

		wr(REG_CTRL1, 1, 8'h08, 8'h00, 8'h00);
		check({7'h00, det_act}, 8'h01);
		cyc(DET + 20);
		flags_m = 2;
		rd(REG_INT, 1, 1);
		check(got[0], expv[0]);
		tdone("forced detection");

		wr(REG_CTRL1, 1, 8'h04, 8'h00, 8'h00);
		check({7'h00, pump_on}, 8'h01);
		@(posedge ref_clk) resetn <= 1'b0;
		cyc(4);
		check({6'h00, pump_on, irq_n}, 8'h01);
		resetn  <= 1'b1;
		ctrl1_m = CTRL1_RESET;
		ctrl2_m = CTRL2_RESET;
		flags_m = FLAGS_RESET;
		cyc(20);
		rd(REG_CTRL1, 3, 1);
		for (int i = 0; i < 3; i++) check(got[i], expv[i]);
		tdone("mid-run reset");
		print_verdict();
	end
endmodule : tb_usb_charger_detect_control
